// *** pkg/crrss_pkg.sv ***
// crrss_pkg: opcode patterns, field positions and reset values for the
// return / rotate / sleep / subtract-from-literal execution slice.
// assumes 16-bit instruction words and an 8-bit data path.
package crrss_pkg;

  // ***********************************************
  // widths
  // ***********************************************
  localparam int INSTR_W = 16;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 21;
  localparam int NIB_W   = 4;

  // ***********************************************
  // opcode patterns
  // ***********************************************
  // return: 0000 0000 0001 001s, s in bit 0
  localparam logic [INSTR_W-2:0] RET_PFX   = 15'h0009;
  localparam int                 RET_S_BIT = 0;
  // rotates: upper six bits, then d, a, 8-bit file address
  localparam int                 ROT_PFX_LSB = 10;
  localparam logic [5:0]         ROT_L_PFX   = 6'h0D;
  localparam logic [5:0]         ROT_R_PFX   = 6'h0C;
  localparam int                 DEST_BIT    = 9;
  localparam int                 ACC_BIT     = 8;
  // subtract-from-literal: upper byte, literal in low byte
  localparam int                 SUBL_PFX_LSB = 8;
  localparam logic [7:0]         SUBL_PFX     = 8'h08;
  localparam logic [INSTR_W-1:0] SLEEP_OP     = 16'h0003;
  // destination select values
  localparam logic               DEST_ACC  = 1'b0;
  localparam logic               DEST_FILE = 1'b1;

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [DATA_W-1:0] W_RST     = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;
  localparam logic              PWRDN_RST = 1'b1;
  localparam logic              TMOUT_RST = 1'b1;
  localparam logic [DATA_W-1:0] ZERO8     = 8'h00;

  // ***********************************************
  // sequencer states, each one bit away from run
  // ***********************************************
  typedef enum logic [1:0] {
    CRRSS_RUN   = 2'b00,
    CRRSS_RET2  = 2'b01,
    CRRSS_SLEEP = 2'b10
  } crrss_state_e;

endpackage : crrss_pkg

// *** logic/crrss_exec.sv ***
// crrss_exec: executes return, rotate left/right through carry, sleep and
// subtract-from-literal for an 8-bit core.
// assumes the core presents the addressed file register on file_rd_data in
// the cycle an instruction is offered, and the stack top on stack_top_entry.
`timescale 1ns/1ns

// Functional notes
// - return pops the stack and loads the popped top entry into the PC.
// - return takes two instruction cycles before the restored instruction runs.
// - rotate destination bit 0 writes the accumulator, 1 writes the file register.
// - rotate left: bit n to n+1, bit 7 to carry, old carry to bit 0.
// - rotate right: bit n to n-1, bit 0 to carry, old carry to bit 7.
// - sleep clears the active-low power-down flag.
// - sleep sets the active-low time-out flag.
// - sleep clears the watchdog counter and its prescaler.
// - subtract-from-literal computes literal minus accumulator, two's complement.
// - subtract-from-literal always writes the accumulator.
// - carry and digit carry are 0 on borrow, 1 otherwise.
module crrss_exec
  import crrss_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // instruction offer
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_word,
  output logic                    instr_ready,
  // operands from the core
  input  wire logic [DATA_W-1:0]  file_rd_data,
  input  wire logic [PC_W-1:0]    stack_top_entry,
  // wake-up source, asynchronous
  input  wire logic               wake_up,
  // program counter and stack
  output logic                    pc_load,
  output logic [PC_W-1:0]         pc_value,
  output logic                    stack_pop,
  output logic                    shadow_restore,
  // file register write
  output logic                    file_wr_en,
  output logic [DATA_W-1:0]       file_wr_addr,
  output logic                    file_wr_bank,
  output logic [DATA_W-1:0]       file_wr_data,
  // accumulator and status
  output logic [DATA_W-1:0]       working_accumulator,
  output logic                    carry,
  output logic                    digit_carry,
  output logic                    zero,
  output logic                    power_down_flag,
  output logic                    timeout_flag,
  // watchdog and power
  output logic                    wdt_clear,
  output logic                    sleeping
);

  // ***********************************************
  // state
  // ***********************************************
  crrss_state_e      state_q;
  crrss_state_e      state_d;
  logic              ready_q;
  logic              pc_load_q;
  logic [PC_W-1:0]   pc_value_q;
  logic              pop_q;
  logic              shadow_q;
  logic              fwe_q;
  logic [DATA_W-1:0] faddr_q;
  logic              fbank_q;
  logic [DATA_W-1:0] fdata_q;
  logic [DATA_W-1:0] w_q;
  logic [DATA_W-1:0] w_d;
  logic              c_q;
  logic              c_d;
  logic              dig_c_q;
  logic              dig_c_d;
  logic              z_q;
  logic              z_d;
  logic              pwrdn_q;
  logic              tmout_q;
  logic              wdt_clr_q;
  logic              sleep_q;
  logic [2:0]        wake_sync_q;

  // ***********************************************
  // decode
  // ***********************************************
  wire               take     = instr_valid & ready_q;
  wire               is_ret   = take & (instr_word[INSTR_W-1:1] == RET_PFX);
  wire [5:0]         rot_pfx  = instr_word[INSTR_W-1:ROT_PFX_LSB];
  wire               is_rl    = take & (rot_pfx == ROT_L_PFX);
  wire               is_rr    = take & (rot_pfx == ROT_R_PFX);
  wire               is_rot   = is_rl | is_rr;
  wire               is_sub   = take & (instr_word[INSTR_W-1:SUBL_PFX_LSB] == SUBL_PFX);
  wire               is_sleep = take & (instr_word == SLEEP_OP);
  wire               dest     = instr_word[DEST_BIT];
  wire [DATA_W-1:0]  literal  = instr_word[DATA_W-1:0];
  wire [DATA_W-1:0]  rot_addr = instr_word[DATA_W-1:0];
  wire               rot_bank = instr_word[ACC_BIT];
  wire               ret_shad = instr_word[RET_S_BIT];
  wire               wr_file  = is_rot & (dest == DEST_FILE);

  // ***********************************************
  // datapath
  // ***********************************************
  wire [DATA_W-1:0]  rot_l_res = {file_rd_data[DATA_W-2:0], c_q};
  wire               rot_l_c   = file_rd_data[DATA_W-1];
  wire [DATA_W-1:0]  rot_r_res = {c_q, file_rd_data[DATA_W-1:1]};
  wire               rot_r_c   = file_rd_data[0];
  wire [DATA_W-1:0]  rot_res   = is_rl ? rot_l_res : rot_r_res;
  wire               rot_c     = is_rl ? rot_l_c : rot_r_c;

  // one extra bit catches the borrow
  wire [DATA_W:0]    sub_full  = {1'b0, literal} - {1'b0, w_q};
  wire [DATA_W-1:0]  sub_res   = sub_full[DATA_W-1:0];
  wire               sub_c     = ~sub_full[DATA_W];
  wire [NIB_W:0]     nib_full  = {1'b0, literal[NIB_W-1:0]} - {1'b0, w_q[NIB_W-1:0]};
  wire               sub_dig_c = ~nib_full[NIB_W];
  wire               sub_z     = (sub_res == ZERO8);

  // wake-up counts once the second and third stages are both high
  wire               wake_seen = wake_sync_q[1] & wake_sync_q[2];

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CRRSS_RUN: begin
        if (is_ret) begin
          state_d = CRRSS_RET2;
        end else if (is_sleep) begin
          state_d = CRRSS_SLEEP;
        end
      end
      CRRSS_RET2: begin
        state_d = CRRSS_RUN;
      end
      CRRSS_SLEEP: begin
        if (wake_seen) begin
          state_d = CRRSS_RUN;
        end
      end
      default: begin
        state_d = CRRSS_RUN;
      end
    endcase
  end

  // ***********************************************
  // accumulator and status next values
  // ***********************************************
  always_comb begin
    w_d     = w_q;
    c_d     = c_q;
    dig_c_d = dig_c_q;
    z_d     = z_q;
    if (is_rot) begin
      c_d = rot_c;
      if (dest == DEST_ACC) begin
        w_d = rot_res;
      end
    end else if (is_sub) begin
      w_d     = sub_res;
      c_d     = sub_c;
      dig_c_d = sub_dig_c;
      z_d     = sub_z;
    end
  end

  // ***********************************************
  // sequencer
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CRRSS_RUN;
      ready_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == CRRSS_RUN);
      sleep_q <= (state_d == CRRSS_SLEEP);
    end
  end

  // ***********************************************
  // wake-up synchroniser
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_sync_q <= 3'h0;
    end else begin
      wake_sync_q <= {wake_sync_q[1:0], wake_up};
    end
  end

  // ***********************************************
  // return: pop and load program counter
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load_q  <= 1'b0;
      pop_q      <= 1'b0;
      shadow_q   <= 1'b0;
      pc_value_q <= PC_RST;
    end else begin
      pc_load_q <= is_ret;
      pop_q     <= is_ret;
      shadow_q  <= is_ret & ret_shad;
      if (is_ret) begin
        pc_value_q <= stack_top_entry;
      end
    end
  end

  // ***********************************************
  // file register write-back
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwe_q   <= 1'b0;
      faddr_q <= ZERO8;
      fbank_q <= 1'b0;
      fdata_q <= ZERO8;
    end else begin
      fwe_q <= wr_file;
      if (is_rot) begin
        faddr_q <= rot_addr;
        fbank_q <= rot_bank;
        fdata_q <= rot_res;
      end
    end
  end

  // ***********************************************
  // accumulator and arithmetic status
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_q     <= W_RST;
      c_q     <= 1'b0;
      dig_c_q <= 1'b0;
      z_q     <= 1'b0;
    end else begin
      w_q     <= w_d;
      c_q     <= c_d;
      dig_c_q <= dig_c_d;
      z_q     <= z_d;
    end
  end

  // ***********************************************
  // power status flags
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwrdn_q <= PWRDN_RST;
      tmout_q <= TMOUT_RST;
    end else begin
      if (is_sleep) begin
        pwrdn_q <= 1'b0;
        tmout_q <= 1'b1;
      end
    end
  end

  // ***********************************************
  // watchdog clear pulse
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= is_sleep;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign instr_ready         = ready_q;
  assign pc_load             = pc_load_q;
  assign pc_value            = pc_value_q;
  assign stack_pop           = pop_q;
  assign shadow_restore      = shadow_q;
  assign file_wr_en          = fwe_q;
  assign file_wr_addr        = faddr_q;
  assign file_wr_bank        = fbank_q;
  assign file_wr_data        = fdata_q;
  assign working_accumulator = w_q;
  assign carry               = c_q;
  assign digit_carry         = dig_c_q;
  assign zero                = z_q;
  assign power_down_flag     = pwrdn_q;
  assign timeout_flag        = tmout_q;
  assign wdt_clear           = wdt_clr_q;
  assign sleeping            = sleep_q;

endmodule : crrss_exec

// *** test/crrss_exec_sva.sv ***
// crrss_exec_sva: port checks of the return, rotate, sleep and subtract slice.
// assumes instruction words follow the opcode patterns of crrss_pkg.
`timescale 1ns/1ns
module crrss_exec_sva
  import crrss_pkg::*;
(
  // clock, reset and instruction offer
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic               instr_ready,
  input wire logic [DATA_W-1:0]  file_rd_data,
  input wire logic [PC_W-1:0]    stack_top_entry,
  // results
  input wire logic               pc_load,
  input wire logic [PC_W-1:0]    pc_value,
  input wire logic               stack_pop,
  input wire logic               file_wr_en,
  input wire logic [DATA_W-1:0]  file_wr_data,
  input wire logic [DATA_W-1:0]  working_accumulator,
  input wire logic               carry,
  input wire logic               digit_carry,
  input wire logic               zero,
  input wire logic               power_down_flag,
  input wire logic               timeout_flag,
  input wire logic               wdt_clear,
  input wire logic               sleeping
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // decode of the taken word
  // ****************
  wire              take    = instr_valid && instr_ready;
  wire              ret     = take && instr_word[INSTR_W-1:1] == RET_PFX;
  wire              rotl    = take && instr_word[INSTR_W-1:ROT_PFX_LSB] == ROT_L_PFX;
  wire              rotr    = take && instr_word[INSTR_W-1:ROT_PFX_LSB] == ROT_R_PFX;
  wire              subl    = take && instr_word[INSTR_W-1:SUBL_PFX_LSB] == SUBL_PFX;
  wire              slp     = take && instr_word == SLEEP_OP;
  wire [DATA_W-1:0] rot_out = file_wr_en ? file_wr_data : working_accumulator;
  // ****************
  // properties
  // ****************
  property p_ret_pop; ret |=> pc_load && stack_pop && pc_value == $past(stack_top_entry); endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return pc load wrong");
  property p_ret_two; ret |=> !instr_ready ##1 instr_ready && !pc_load; endproperty
  a_ret_two: assert property (p_ret_two) else $error("return length wrong");
  property p_rot_dest; rotl || rotr |=> file_wr_en == $past(instr_word[DEST_BIT]); endproperty
  a_rot_dest: assert property (p_rot_dest) else $error("rotate destination wrong");
  property p_rot_left; rotl |=> carry == $past(file_rd_data[7])
    && rot_out == {$past(file_rd_data[6:0]), $past(carry)}; endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");
  property p_rot_right; rotr |=> carry == $past(file_rd_data[0])
    && rot_out == {$past(carry), $past(file_rd_data[7:1])}; endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");
  property p_sleep_pd; slp |=> !power_down_flag; endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("power down flag wrong");
  property p_sleep_to; slp |=> timeout_flag; endproperty
  a_sleep_to: assert property (p_sleep_to) else $error("timeout flag wrong");
  property p_sleep_wdt; slp |=> wdt_clear ##1 !wdt_clear; endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog clear wrong");
  property p_sub_acc; subl |=> working_accumulator == $past(instr_word[7:0]) - $past(working_accumulator); endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong");
  property p_sub_flags; subl |=> carry == ($past(working_accumulator) <= $past(instr_word[7:0]))
    && digit_carry == ($past(working_accumulator[3:0]) <= $past(instr_word[3:0])); endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract carries wrong");
  property p_sub_zero; subl |=> zero == (working_accumulator == ZERO8); endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("subtract zero wrong");
  property p_halt; sleeping |-> !instr_ready; endproperty
  a_halt: assert property (p_halt) else $error("offer taken while asleep");
endmodule : crrss_exec_sva

bind crrss_exec crrss_exec_sva i_sva (
  .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
  .file_rd_data(file_rd_data), .stack_top_entry(stack_top_entry), .pc_load(pc_load), .pc_value(pc_value),
  .stack_pop(stack_pop), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .carry(carry),
  .working_accumulator(working_accumulator), .digit_carry(digit_carry), .zero(zero), .sleeping(sleeping),
  .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .wdt_clear(wdt_clear)
);

// *** test/tb_cpu_return_rotate_sleep_sub_exec.sv ***
// tb_cpu_return_rotate_sleep_sub_exec: directed checks of crrss_exec at its ports.
// assumes a 50 MHz clock and the opcode patterns of crrss_pkg.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_cpu_return_rotate_sleep_sub_exec
  import crrss_pkg::*;
;
  logic               clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, wake_up = 1'b0;
  logic [INSTR_W-1:0] instr_word = '0;
  logic [DATA_W-1:0]  file_rd_data = '0, w_m = W_RST, file_wr_addr, file_wr_data, working_accumulator;
  logic [PC_W-1:0]    stack_top_entry = '0, pc_value;
  logic               instr_ready, pc_load, stack_pop, shadow_restore, file_wr_en, file_wr_bank, c_m;
  logic               carry, digit_carry, zero, power_down_flag, timeout_flag, wdt_clear, sleeping;
  int                 n_mismatch = 0, check_count = 0;
  always #10 clk = ~clk;
  crrss_exec i_dut (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
    .file_rd_data(file_rd_data), .stack_top_entry(stack_top_entry), .wake_up(wake_up), .pc_load(pc_load),
    .pc_value(pc_value), .stack_pop(stack_pop), .shadow_restore(shadow_restore), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_bank(file_wr_bank), .file_wr_data(file_wr_data), .carry(carry),
    .working_accumulator(working_accumulator), .digit_carry(digit_carry), .zero(zero), .sleeping(sleeping),
    .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .wdt_clear(wdt_clear)
  );
  // ****************
  // drivers, all at the falling edge
  // ****************
  task results;
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // waits for ready, offers, returns one cycle later with valid still up
  task automatic issue(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] f);
    int n;
    n = 0;
    while (instr_ready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        results;
      end
      @(negedge clk);
    end
    instr_valid = 1'b1;
    instr_word = w;
    file_rd_data = f;
    @(negedge clk);
  endtask : issue
  task idle;
    instr_valid = 1'b0;
    file_rd_data = ~file_rd_data;
    @(negedge clk);
  endtask : idle
  // ****************
  // scenarios
  // ****************
  task automatic t_subl;
    logic [7:0] wv [4] = '{8'h05, 8'h06, 8'h10, 8'h01};
    logic [7:0] kv [4] = '{8'h05, 8'h05, 8'h0F, 8'hF0};
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      issue({SUBL_PFX, 8'(wv[i] + w_m)}, 8'h00);
      w_m = wv[i];
      issue({SUBL_PFX, kv[i]}, 8'h00);
      d = kv[i] - w_m;
      c_m = (w_m <= kv[i]);
      `CHK("acc", d, working_accumulator)
      `CHK("carry", c_m, carry)
      `CHK("digit_carry", (w_m[3:0] <= kv[i][3:0]), digit_carry)
      `CHK("zero", (d == 8'h00), zero)
      w_m = d;
    end
  endtask : t_subl
  // back to back, carry chains from one rotate to the next
  task automatic t_rot;
    logic [7:0] fv [4] = '{8'hE6, 8'h3C, 8'h81, 8'h5A};
    logic [7:0] r;
    logic       l, dd;
    for (int i = 0; i < 4; i++) begin
      l = (i < 2);
      dd = i[0];
      r = l ? {fv[i][6:0], c_m} : {c_m, fv[i][7:1]};
      issue({l ? ROT_L_PFX : ROT_R_PFX, dd, i[1], 8'(8'h20 + i)}, fv[i]);
      c_m = l ? fv[i][7] : fv[i][0];
      `CHK("carry", c_m, carry)
      `CHK("wr_en", dd, file_wr_en)
      `CHK("result", r, (dd ? file_wr_data : working_accumulator))
      if (dd) `CHK("addr", {i[1], 8'(8'h20 + i)}, {file_wr_bank, file_wr_addr})
      if (!dd) w_m = r;
    end
    `CHK("acc", w_m, working_accumulator)
  endtask : t_rot
  task automatic t_ret;
    logic [PC_W-1:0] p;
    for (int s = 0; s < 2; s++) begin
      p = 21'h1ABCDE ^ 21'(s);
      stack_top_entry = p;
      issue({RET_PFX, 1'(s)}, 8'h00);
      stack_top_entry = ~p;
      `CHK("pop", 2'b11, {pc_load, stack_pop})
      `CHK("pc", p, pc_value)
      `CHK("shadow", 1'(s), shadow_restore)
      `CHK("ready", 1'b0, instr_ready)
      idle;
      `CHK("ready", 1'b1, instr_ready)
      `CHK("pc_load", 1'b0, pc_load)
    end
  endtask : t_ret
  task automatic t_sleep;
    int n;
    issue(SLEEP_OP, 8'h00);
    instr_valid = 1'b0;
    `CHK("power_down_flag", 1'b0, power_down_flag)
    `CHK("timeout_flag", 1'b1, timeout_flag)
    `CHK("wdt", 1'b1, wdt_clear)
    repeat (5) @(negedge clk);
    `CHK("wdt", 1'b0, wdt_clear)
    `CHK("halt", 2'b10, {sleeping, instr_ready})
    wake_up = 1'b1;
    n = 0;
    while (sleeping !== 1'b0) begin
      n++;
      if (n > 10) begin
        n_mismatch++;
        results;
      end
      @(negedge clk);
    end
    wake_up = 1'b0;
    issue(16'hFFFF, 8'h00);
    `CHK("acc", w_m, working_accumulator)
  endtask : t_sleep
  initial begin
    repeat (4) @(negedge clk);
    `CHK("reset", 3'b110, {power_down_flag, timeout_flag, instr_ready})
    rst = 1'b0;
    @(negedge clk);
    t_subl;
    t_rot;
    t_ret;
    t_sleep;
    idle;
    results;
  end
endmodule : tb_cpu_return_rotate_sleep_sub_exec
